// File: design/cam_addr_mux.sv
// Output multiplexer that turns the address counter into the memory address pins.
// Assumes the caller registers the result before it leaves the chip.
`timescale 1ns/1ps
module cam_addr_mux (
	// Counter side and result.
	cam_addr_if.mux bus
);
	wire [15:0] word_addr; // Counter shifted up by one for word mode.
	wire [15:0] mode_addr; // Byte or word selection.
	wire        wrap_bit;  // Counter bit that lands on output bit 0.
	wire        sub13;     // Address bit 13 after row scan substitution.
	wire        sub14;     // Address bit 14 after row scan substitution.

	// Word mode moves every bit up one place and feeds bit 0 from a high bit.
	assign wrap_bit  = bus.mode.addr_wrap ? bus.counter[15] : bus.counter[13];
	assign word_addr = {bus.counter[14:0], wrap_bit};
	assign mode_addr = bus.mode.byte_word_select ? bus.counter : word_addr;

	// Row scan substitution only applies while the display is active.
	assign sub13 = (bus.active && !bus.mode.cga_compat_bit) ? bus.row_scan[0] : mode_addr[13];
	assign sub14 = (bus.active && !bus.mode.row_scan_select_bit) ? bus.row_scan[1] : mode_addr[14];
	// One assignment drives the whole result, so the bundle member has a single driver.
	assign bus.addr = {mode_addr[15], sub14, sub13, mode_addr[12:0]};
endmodule : cam_addr_mux

// File: design/cam_crtc_top.sv
// CRT controller address generator with mode control, split screen and signature readback.
// Assumes host port strobes and display_active come from logic on core_clk; both clocks come from pins.
// Overview of operation
// - Retraces only while retrace enable is set.
// - Word mode shifts counter bits up one.
// - Word mode bit 0 from counter 13 or 15.
// - Byte mode passes counter bits straight through.
// - Count by two halves address counter rate.
// - Vertical doubling halves line counter clock.
// - Line counter holds 512 lines, 1024 doubled.
// - Row scan bit 1 replaces address bit 14.
// - Row scan bit 0 replaces address bit 13.
// - Line compare is nine bits, msb in overflow.
// - Compare match reloads address and row from screen B.
// - Screen B registers clear at reset.
// - Signature reads start high XOR constant.
// - Writes to the signature index are discarded.
// - Reset clears the retrace enable bit.
`timescale 1ns/1ps
`include "cam_cfg.svh"
module cam_crtc_top (
	// Clock and reset.
	input  wire logic        core_clk,
	input  wire logic        rst,
	// Host indexed I/O port.
	input  wire logic        io_index_wr,
	input  wire logic        io_data_wr,
	input  wire logic        io_data_rd,
	input  wire logic [7:0]  io_wdata,
	output logic      [7:0]  io_rdata,
	// Timing inputs from the pins and from the horizontal logic.
	input  wire logic        char_clk_in,
	input  wire logic        hretrace_clk_in,
	input  wire logic        display_active,
	// Display memory address and retrace outputs.
	output logic      [15:0] mem_addr,
	output logic             hretrace_out,
	output logic             vretrace_out
);
	// Builds a nine-bit value from an overflow bit and a low byte.
	function automatic logic [8:0] cat9(input logic msb, input logic [7:0] lo);
		cat9 = {msb, lo};
	endfunction : cat9

	// Host-visible registers.
	logic [7:0]         index_q;    // Selected register index.
	cam_pkg::cam_mode_t mode_q;     // Mode control register.
	logic [7:0]         lcmp_q;     // Split line compare, low bits.
	logic [7:0]         ovf_q;      // Overflow bits.
	logic [7:0]         vtotal_q;   // Vertical total, low bits.
	logic [7:0]         vrs_q;      // Vertical retrace start, low bits.
	logic [7:0]         maxscan_q;  // Last row scan of a character row.
	logic [7:0]         offset_q;   // Logical line width.
	logic [7:0]         start_hi_q; // Screen A start, high byte.
	logic [7:0]         start_lo_q; // Screen A start, low byte.
	logic [7:0]         sb_hi_q;    // Screen B start, high byte.
	logic [7:0]         sb_lo_q;    // Screen B start, low byte.
	logic [7:0]         sb_row_q;   // Screen B preset row scan.
	// Synchronisers; stage one feeds only stage two.
	logic               cc_s1_q, cc_s2_q, cc_s3_q;
	logic               hr_s1_q, hr_s2_q, hr_s3_q;
	// Dividers and counters.
	logic               char_div_q; // Alternates on each character clock.
	logic               hr_div_q;   // Alternates on each horizontal retrace clock.
	logic [8:0]         line_q;     // Vertical scan line counter.
	logic [4:0]         row_q;      // Character row scan counter.
	logic [15:0]        cnt_q;      // Memory address counter.
	logic [15:0]        lstart_q;   // Start address of the current character row.
	logic [7:0]         rd_val;     // Read data selected by the index.

	// Edge detection reads only the second and third synchroniser stages.
	wire char_tick = cc_s2_q && !cc_s3_q;
	wire hr_tick   = hr_s2_q && !hr_s3_q;
	wire adv       = char_tick && (!mode_q.count_by_two_bit || char_div_q);
	wire line_tick = hr_tick && (!mode_q.vertical_double_bit || hr_div_q);

	// Nine-bit vertical values.
	wire [8:0] vtotal9 = cat9(ovf_q[`CAM_OVF_VT8], vtotal_q);
	wire [8:0] vrs9    = cat9(ovf_q[`CAM_OVF_VRS8], vrs_q);
	wire [8:0] lcmp9   = cat9(ovf_q[`CAM_OVF_LC8], lcmp_q);

	// Next line values; a frame end wins over a split match, which wins over a row wrap.
	wire        frame_end = (line_q == vtotal9);
	wire [8:0]  line_d    = frame_end ? 9'h000 : line_q + 9'h001;
	wire        split_hit = !frame_end && (line_d == lcmp9);
	wire        row_wrap  = (row_q == maxscan_q[4:0]);
	wire [15:0] stride    = mode_q.byte_word_select ? {7'h00, offset_q, 1'b0} : {6'h00, offset_q, 2'b00};
	wire [15:0] lstart_d  = frame_end ? {start_hi_q, start_lo_q} :
	                        split_hit ? {sb_hi_q, sb_lo_q} :
	                        row_wrap  ? lstart_q + stride : lstart_q;
	wire [4:0]  row_d     = frame_end ? 5'h00 : split_hit ? sb_row_q[4:0] : row_wrap ? 5'h00 : row_q + 5'h01;
	wire        vr_window = (line_q >= vrs9) && (line_q < vrs9 + `CAM_VRETRACE_LINES);

	// Readback; the signature is formed at the time of the read.
	always_comb begin
		unique case (index_q)
			`CAM_IDX_MODE:     rd_val = mode_q;
			`CAM_IDX_LCMP:     rd_val = lcmp_q;
			`CAM_IDX_OVERFLOW: rd_val = ovf_q;
			`CAM_IDX_VTOTAL:   rd_val = vtotal_q;
			`CAM_IDX_VRSTART:  rd_val = vrs_q;
			`CAM_IDX_MAXSCAN:  rd_val = maxscan_q;
			`CAM_IDX_OFFSET:   rd_val = offset_q;
			`CAM_IDX_START_HI: rd_val = start_hi_q;
			`CAM_IDX_START_LO: rd_val = start_lo_q;
			`CAM_IDX_SB_HI:    rd_val = sb_hi_q;
			`CAM_IDX_SB_LO:    rd_val = sb_lo_q;
			`CAM_IDX_SB_ROW:   rd_val = sb_row_q;
			`CAM_IDX_SIG:      rd_val = start_hi_q ^ `CAM_SIG_XOR;
			default:           rd_val = 8'h00;                     // Unmapped indices read zero.
		endcase
	end

	// Host port: index first, then data at that index.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			index_q  <= 8'h00;
			io_rdata <= 8'h00;
		end else begin
			if (io_index_wr) begin
				index_q <= io_wdata;
			end
			if (io_data_rd) begin
				io_rdata <= rd_val;
			end
		end
	end

	// Register writes; the signature index has no case, so its writes fall away.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			mode_q     <= cam_pkg::cam_mode_t'(`CAM_MODE_RST);
			{lcmp_q, ovf_q, vtotal_q, vrs_q, maxscan_q, offset_q, start_hi_q, start_lo_q} <= {8{`CAM_REG_RST}};
			{sb_hi_q, sb_lo_q, sb_row_q} <= {3{`CAM_REG_RST}};
		end else if (io_data_wr) begin
			unique case (index_q)
				`CAM_IDX_MODE:     mode_q     <= cam_pkg::cam_mode_t'(io_wdata);
				`CAM_IDX_LCMP:     lcmp_q     <= io_wdata;
				`CAM_IDX_OVERFLOW: ovf_q      <= io_wdata;
				`CAM_IDX_VTOTAL:   vtotal_q   <= io_wdata;
				`CAM_IDX_VRSTART:  vrs_q      <= io_wdata;
				`CAM_IDX_MAXSCAN:  maxscan_q  <= io_wdata;
				`CAM_IDX_OFFSET:   offset_q   <= io_wdata;
				`CAM_IDX_START_HI: start_hi_q <= io_wdata;
				`CAM_IDX_START_LO: start_lo_q <= io_wdata;
				`CAM_IDX_SB_HI:    sb_hi_q    <= io_wdata;
				`CAM_IDX_SB_LO:    sb_lo_q    <= io_wdata;
				`CAM_IDX_SB_ROW:   sb_row_q   <= io_wdata;
				default:           ;
			endcase
		end
	end

	// Two flip-flops per pin clock, then a third stage for the edge.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			{cc_s1_q, cc_s2_q, cc_s3_q} <= 3'h0;
			{hr_s1_q, hr_s2_q, hr_s3_q} <= 3'h0;
		end else begin
			{cc_s1_q, cc_s2_q, cc_s3_q} <= {char_clk_in, cc_s1_q, cc_s2_q};
			{hr_s1_q, hr_s2_q, hr_s3_q} <= {hretrace_clk_in, hr_s1_q, hr_s2_q};
		end
	end

	// Dividers, counters and the address generator.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			char_div_q <= 1'b0;
			hr_div_q   <= 1'b0;
			line_q     <= 9'h000;
			row_q      <= 5'h00;
			cnt_q      <= 16'h0000;
			lstart_q   <= 16'h0000;
		end else begin
			char_div_q <= char_div_q ^ char_tick;
			hr_div_q   <= hr_div_q ^ hr_tick;
			if (line_tick) begin
				// A new line restarts the counter at its row start.
				line_q   <= line_d;
				row_q    <= row_d;
				lstart_q <= lstart_d;
				cnt_q    <= lstart_d;
			end else if (adv && display_active) begin
				cnt_q <= cnt_q + 16'h0001;
			end
		end
	end

	// Address multiplexer in its own module.
	cam_addr_if addr_bus ();
	assign addr_bus.counter  = cnt_q;
	assign addr_bus.mode     = mode_q;
	assign addr_bus.row_scan = row_q;
	assign addr_bus.active   = display_active;
	cam_addr_mux u_mux (
		.bus (addr_bus.mux)
	);

	// Registered outputs; retraces are gated by the enable bit.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			mem_addr     <= 16'h0000;
			hretrace_out <= 1'b0;
			vretrace_out <= 1'b0;
		end else begin
			mem_addr     <= addr_bus.addr;
			hretrace_out <= mode_q.retrace_en && hr_s2_q;
			vretrace_out <= mode_q.retrace_en && vr_window;
		end
	end

	// Checks on the finished behaviour, all in the core clock domain.
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	sequence s_held_tick;
		char_tick && mode_q.count_by_two_bit && !char_div_q && !line_tick;
	endsequence

	retrace_gate_a: assert property (!mode_q.retrace_en |=> !hretrace_out && !vretrace_out)
		else $error("Retrace driven while disabled.");
	word_shift_a: assert property (!mode_q.byte_word_select |=> mem_addr[15] == $past(cnt_q[14]))
		else $error("Word mode shift wrong.");
	wrap_select_a: assert property (!mode_q.byte_word_select |=>
		mem_addr[0] == ($past(mode_q.addr_wrap) ? $past(cnt_q[15]) : $past(cnt_q[13])))
		else $error("Word mode bit zero wrong.");
	byte_pass_a: assert property ((mode_q.byte_word_select && mode_q.cga_compat_bit &&
		mode_q.row_scan_select_bit) |=> mem_addr == $past(cnt_q))
		else $error("Byte mode address altered.");
	count_two_a: assert property (s_held_tick |=> cnt_q == $past(cnt_q))
		else $error("Counter advanced on skipped character clock.");
	vert_double_a: assert property ((hr_tick && mode_q.vertical_double_bit && !hr_div_q) |=>
		line_q == $past(line_q))
		else $error("Line counter advanced on skipped retrace clock.");
	row_bit13_a: assert property ((display_active && !mode_q.cga_compat_bit) |=>
		mem_addr[13] == $past(row_q[0]))
		else $error("Row scan bit 0 not on address bit 13.");
	row_bit14_a: assert property ((display_active && !mode_q.row_scan_select_bit) |=>
		mem_addr[14] == $past(row_q[1]))
		else $error("Row scan bit 1 not on address bit 14.");
	split_load_a: assert property ((line_tick && split_hit) |=>
		cnt_q == {$past(sb_hi_q), $past(sb_lo_q)} && row_q == $past(sb_row_q[4:0]))
		else $error("Split screen reload wrong.");
	sig_read_a: assert property ((io_data_rd && index_q == `CAM_IDX_SIG) |=>
		io_rdata == ($past(start_hi_q) ^ `CAM_SIG_XOR))
		else $error("Signature readback wrong.");
	sig_write_a: assert property ((io_data_wr && index_q == `CAM_IDX_SIG) |=>
		$stable(mode_q) && $stable(lcmp_q) && $stable(start_hi_q))
		else $error("Signature write changed a register.");
endmodule : cam_crtc_top

// File: inc/cam_addr_if.sv
// Bundle between the address counter and the output multiplexer.
// Assumes both ends sit in the same clock domain; the bundle itself holds no state.
`timescale 1ns/1ps
interface cam_addr_if;
	logic [15:0]       counter;  // Internal memory address counter.
	cam_pkg::cam_mode_t mode;    // Current mode control fields.
	logic [4:0]        row_scan; // Character row scan counter.
	logic              active;   // Active display time.
	logic [15:0]       addr;     // Multiplexed address toward the pins.

	modport src (output counter, output mode, output row_scan, output active, input addr);
	modport mux (input counter, input mode, input row_scan, input active, output addr);
endinterface : cam_addr_if

// File: inc/cam_cfg.svh
// Register indices, field positions, reset values and timing figures of the CRT address block.
// Assumes it is included by bare name from files that need the constants.
`ifndef CAM_CFG_SVH
`define CAM_CFG_SVH

// Register indices seen through the indexed data port.
`define CAM_IDX_VTOTAL   8'h06
`define CAM_IDX_OVERFLOW 8'h07
`define CAM_IDX_MAXSCAN  8'h09
`define CAM_IDX_START_HI 8'h0c
`define CAM_IDX_START_LO 8'h0d
`define CAM_IDX_VRSTART  8'h10
`define CAM_IDX_OFFSET   8'h13
`define CAM_IDX_MODE     8'h17
`define CAM_IDX_LCMP     8'h18
`define CAM_IDX_SB_HI    8'h1a
`define CAM_IDX_SB_LO    8'h1b
`define CAM_IDX_SB_ROW   8'h1c
`define CAM_IDX_SIG      8'h1f

// Bit positions inside the overflow register.
`define CAM_OVF_VT8  0
`define CAM_OVF_VRS8 2
`define CAM_OVF_LC8  4

// Reset values; the retrace enable must come up cleared.
`define CAM_MODE_RST 8'h00
`define CAM_REG_RST  8'h00

// Signature XOR constant; the value is arbitrary.
`define CAM_SIG_XOR 8'h5c

// Vertical retrace pulse length in scan lines.
`define CAM_VRETRACE_LINES 9'h002

`endif

// File: inc/cam_pkg.sv
// Types shared by the CRT address block and its output multiplexer.
// Assumes no other package; users name everything with the cam_pkg:: prefix.
package cam_pkg;

	// Layout of the mode control register, msb first.
	typedef struct packed {
		logic retrace_en;          // Enables both retraces.
		logic byte_word_select;    // One selects byte mode.
		logic addr_wrap;           // Picks counter bit 15 or 13 for output bit 0.
		logic spare;               // Stored only.
		logic count_by_two_bit;    // Halves the address counter rate.
		logic vertical_double_bit; // Halves the line counter rate.
		logic row_scan_select_bit; // Zero substitutes row scan bit 1.
		logic cga_compat_bit;      // Zero substitutes row scan bit 0.
	} cam_mode_t;

endpackage : cam_pkg

// File: verification/cam_pin_model.sv
// Far-side pin model that drives the character clock and horizontal retrace clock pins.
// Assumes the bench calls its tasks by hierarchical name; pins change on the falling core edge.
`timescale 1ns/1ps
module cam_pin_model (
	// Reference clock.
	input  wire logic core_clk,
	// Pin clocks toward the block.
	output logic      char_clk_in,
	output logic      hretrace_clk_in
);
	logic [1:0] pins; // Retrace pin in bit 1, character pin in bit 0.

	// A stopped source rests both pins low between bursts.
	initial begin
		pins = 2'b00;
	end

	assign {hretrace_clk_in, char_clk_in} = pins;

	// Sends n pulses; each phase lasts three core cycles, above the two-cycle minimum.
	task automatic burst(input bit line, input int n);
		repeat (n) begin
			repeat (3) @(negedge core_clk);
			pins = line ? 2'b10 : 2'b01;
			repeat (3) @(negedge core_clk);
			pins = 2'b00;
		end
	endtask : burst

	// Parks the retrace pin at a level, so the retrace output gating can be seen.
	task automatic hold(input logic lvl);
		@(negedge core_clk);
		pins = {lvl, 1'b0};
	endtask : hold
endmodule : cam_pin_model

// File: verification/tb_top.sv
// Self-checking bench for the CRT address block: registers, retrace gating, split screen, rates.
// Assumes the block and pin model compile first; inputs change on the falling clock edge.
`timescale 1ns/1ps
`include "cam_cfg.svh"
module tb_top;
	logic        core_clk;        // System clock, 200 MHz.
	logic        rst;             // Active high reset.
	logic        io_index_wr;     // Index port strobe.
	logic        io_data_wr;      // Data port write strobe.
	logic        io_data_rd;      // Data port read strobe.
	logic [7:0]  io_wdata;        // Host write data.
	logic [7:0]  io_rdata;        // Host read data.
	logic        char_clk_in;     // Character clock pin.
	logic        hretrace_clk_in; // Horizontal retrace clock pin.
	logic        display_active;  // Active display level.
	logic [15:0] mem_addr;        // Display memory address.
	logic        hretrace_out;    // Gated horizontal retrace.
	logic        vretrace_out;    // Gated vertical retrace.
	int          fails;           // Mismatches seen.
	int          samples_checked; // Comparisons made.
	logic [15:0] v;               // Screen B start under test.
	logic [7:0]  r;               // Random register value.
	logic [7:0]  m;               // Mode value under test.

	cam_crtc_top i_cam_crtc_top (.core_clk(core_clk), .rst(rst), .io_index_wr(io_index_wr),
		.io_data_wr(io_data_wr), .io_data_rd(io_data_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
		.char_clk_in(char_clk_in), .hretrace_clk_in(hretrace_clk_in), .display_active(display_active),
		.mem_addr(mem_addr), .hretrace_out(hretrace_out), .vretrace_out(vretrace_out));
	cam_pin_model i_pins (.core_clk(core_clk), .char_clk_in(char_clk_in), .hretrace_clk_in(hretrace_clk_in));

	// Clock at a 5 ns period.
	always #2.5 core_clk = ~core_clk;

	// Compares one value and reports a mismatch at once.
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
		end
	endtask : chk

	// Index write then data write; each strobe stands one cycle.
	task automatic wr(input logic [7:0] idx, input logic [7:0] val);
		@(negedge core_clk);
		io_index_wr = 1'b1;
		io_wdata    = idx;
		@(negedge core_clk);
		io_index_wr = 1'b0;
		io_data_wr  = 1'b1;
		io_wdata    = val;
		@(negedge core_clk);
		io_data_wr  = 1'b0;
	endtask : wr

	// Index write then read; data is sampled a full cycle after the read is taken.
	task automatic rd(input string name, input logic [7:0] idx, input logic [7:0] exp);
		@(negedge core_clk);
		io_index_wr = 1'b1;
		io_wdata    = idx;
		@(negedge core_clk);
		io_index_wr = 1'b0;
		io_data_rd  = 1'b1;
		@(negedge core_clk);
		io_data_rd  = 1'b0;
		@(negedge core_clk);
		chk(name, {8'h00, io_rdata}, {8'h00, exp});
	endtask : rd

	// Holds reset for five cycles.
	task automatic do_reset();
		rst            = 1'b1;
		display_active = 1'b0;
		repeat (5) @(negedge core_clk);
		rst = 1'b0;
	endtask : do_reset

	// Programs a frame with a split at the given compare and screen B start v at row 1.
	task automatic setup(input logic [7:0] ovf, input logic [7:0] lcmp, input logic [7:0] md);
		wr(`CAM_IDX_VTOTAL, 8'h20);
		wr(`CAM_IDX_OVERFLOW, ovf);
		wr(`CAM_IDX_LCMP, lcmp);
		wr(`CAM_IDX_MAXSCAN, 8'h1f);
		wr(`CAM_IDX_SB_HI, v[15:8]);
		wr(`CAM_IDX_SB_LO, v[7:0]);
		wr(`CAM_IDX_SB_ROW, 8'h01);
		wr(`CAM_IDX_MODE, md);
	endtask : setup

	// Expected pin address for a counter value, mode, display level and row scan.
	function automatic logic [15:0] exp_addr(input logic [15:0] c, input logic [7:0] md, input logic act,
		input logic [1:0] row);
		cam_pkg::cam_mode_t f;
		logic [15:0]        a;
		f     = md;
		a     = f.byte_word_select ? c : {c[14:0], (f.addr_wrap ? c[15] : c[13])};
		a[13] = (act && !f.cga_compat_bit) ? row[0] : a[13];
		a[14] = (act && !f.row_scan_select_bit) ? row[1] : a[14];
		return a;
	endfunction : exp_addr

	// Prints the counts and the verdict, then stops.
	task automatic close_out();
		$display("checks %0d, mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : close_out

	// Cuts a hang short.
	initial begin
		repeat (100000) @(posedge core_clk);
		fails++;
		close_out();
	end

	// Main sequence.
	initial begin
		core_clk        = 1'b0;
		rst             = 1'b1;
		io_index_wr     = 1'b0;
		io_data_wr      = 1'b0;
		io_data_rd      = 1'b0;
		io_wdata        = 8'h00;
		display_active  = 1'b0;
		fails           = 0;
		samples_checked = 0;
		r               = $urandom(32'h7271);
		do_reset();
		rd("mode_rst", `CAM_IDX_MODE, `CAM_MODE_RST);
		for (int i = 0; i < 3; i++) begin
			rd("screen_b_rst", `CAM_IDX_SB_HI + i[7:0], 8'h00);
		end
		// Random register traffic; the signature write must leave everything alone.
		repeat (4) begin
			r = $urandom;
			m = $urandom;
			wr(`CAM_IDX_START_HI, r);
			wr(`CAM_IDX_MODE, m);
			rd("mode", `CAM_IDX_MODE, m);
			rd("signature", `CAM_IDX_SIG, r ^ `CAM_SIG_XOR);
			wr(`CAM_IDX_SIG, ~r);
			rd("sig_after_wr", `CAM_IDX_SIG, r ^ `CAM_SIG_XOR);
			rd("start_hi", `CAM_IDX_START_HI, r);
			rd("unmapped", 8'h3f, 8'h00);
		end
		// Retrace gating with the pin parked high.
		wr(`CAM_IDX_MODE, 8'h00);
		i_pins.hold(1'b1);
		repeat (8) @(negedge core_clk);
		chk("hretrace_off", {15'h0000, hretrace_out}, 16'h0000);
		chk("vretrace_off", {15'h0000, vretrace_out}, 16'h0000);
		wr(`CAM_IDX_MODE, 8'h80);
		repeat (8) @(negedge core_clk);
		chk("hretrace_on", {15'h0000, hretrace_out}, 16'h0001);
		// Line 0 lies in the two-line window that opens at the cleared retrace start.
		chk("vretrace_on", {15'h0000, vretrace_out}, 16'h0001);
		// Moving the window away from line 0 and lowering the pin must drop both retraces.
		wr(`CAM_IDX_VRSTART, 8'h05);
		i_pins.hold(1'b0);
		repeat (8) @(negedge core_clk);
		chk("hretrace_low", {15'h0000, hretrace_out}, 16'h0000);
		chk("vretrace_window", {15'h0000, vretrace_out}, 16'h0000);
		// Compare value 0x102 with its msb in the overflow register; line 2 must not split.
		// Screen B start is kept nonzero so that it can never match the screen A start of zero.
		do_reset();
		v = 16'($urandom) | 16'h0001;
		setup(8'h11, 8'h02, 8'hc3);
		i_pins.burst(1'b1, 2);
		repeat (6) @(negedge core_clk);
		chk("early_split", {15'h0000, mem_addr === v}, 16'h0000);
		i_pins.burst(1'b1, 256);
		repeat (6) @(negedge core_clk);
		chk("split_load", mem_addr, v);
		// Every byte, wrap and substitution mix, with a random display level.
		for (int k = 0; k < 16; k++) begin
			m              = {1'b1, k[3:2], 3'b000, k[1:0]};
			display_active = $urandom;
			wr(`CAM_IDX_MODE, m);
			repeat (3) @(negedge core_clk);
			chk("mux", mem_addr, exp_addr(v, m, display_active, 2'b01));
		end
		// Halved line rate: compare programmed at half of the eight lines wanted.
		do_reset();
		v = 16'($urandom) | 16'h0001;
		setup(8'h00, 8'h04, 8'hcf);
		i_pins.burst(1'b1, 6);
		repeat (6) @(negedge core_clk);
		chk("half_line", {15'h0000, mem_addr === v}, 16'h0000);
		i_pins.burst(1'b1, 2);
		repeat (6) @(negedge core_clk);
		chk("double_line", mem_addr, v);
		// Address counter rate, halved then full.
		display_active = 1'b1;
		i_pins.burst(1'b0, 8);
		repeat (6) @(negedge core_clk);
		chk("char_half", mem_addr, v + 16'h0004);
		wr(`CAM_IDX_MODE, 8'hc7);
		i_pins.burst(1'b0, 8);
		repeat (6) @(negedge core_clk);
		chk("char_full", mem_addr, v + 16'h000c);
		// Split disabled the usual way; the frame wraps to screen A start and never reloads screen B.
		display_active = 1'b0;
		wr(`CAM_IDX_START_HI, 8'h12);
		wr(`CAM_IDX_START_LO, 8'h34);
		wr(`CAM_IDX_OVERFLOW, 8'h10);
		wr(`CAM_IDX_LCMP, 8'hff);
		i_pins.burst(1'b1, 80);
		repeat (6) @(negedge core_clk);
		chk("split_off", mem_addr, 16'h1234);
		close_out();
	end
endmodule : tb_top
